// [bed_pkg.sv]
// constants for the break event detector: register offsets, bit positions, reset values
// assumes a 32-bit apb register bus with byte addresses on paddr
package bed_pkg;
  // ********************************
  // address map
  // ********************************
  localparam int unsigned ADDR_W            = 8;
  localparam logic [7:0]  OFF_IRQ_LOW_EN    = 8'h00;
  localparam logic [7:0]  OFF_IRQ_HIGH_EN   = 8'h04;
  localparam logic [7:0]  OFF_MISC_EN       = 8'h08;
  localparam logic [7:0]  OFF_DMA_EN        = 8'h0C;
  localparam logic [7:0]  OFF_STATUS        = 8'h10;
  localparam logic [7:0]  OFF_MASK          = 8'h14;
  // ********************************
  // field layout
  // ********************************
  localparam int unsigned REG_W             = 8;
  localparam int unsigned IRQ_LINES         = 16;
  localparam int unsigned DMA_CHANS         = 8;
  localparam int unsigned MISC_GLOBAL       = 0;
  localparam int unsigned MISC_INTR         = 1;
  localparam int unsigned MISC_NMI          = 2;
  localparam int unsigned MISC_PERR         = 3;
  localparam int unsigned MISC_IOCHK        = 4;
  localparam int unsigned MISC_TMR_CLR      = 5;
  localparam int unsigned MISC_SERR         = 6;
  localparam logic [7:0]  MISC_WMASK        = 8'h7F;
  localparam int unsigned STAT_W            = 2;
  localparam int unsigned STAT_WAKE         = 0;
  localparam int unsigned STAT_TMR_CLR      = 1;
  // ********************************
  // reset values
  // ********************************
  localparam logic [7:0]  EN_RST            = 8'h00;
  localparam logic [1:0]  STAT_RST          = 2'h0;
  localparam logic        PM_ACT_RST        = 1'b0;
  localparam logic [31:0] RD_ZERO           = 32'h0000_0000;
endpackage : bed_pkg

// [bed_break_event_detect.sv]
// break event detector: watches interrupt, dma and error lines, wakes the power sequencer
// assumes all inputs synchronous to ref_clk and an apb master on the register port
//
// Functional notes
// - bits 0-7 of first enable register enable wake on interrupt requests 0-7.
// - second enable register bits 0-7 enable wake on interrupt requests 8-15.
// - an enabled source found active drives the activity output to its high level.
// - misc bit 6 enables pci system error as a wake event.
// - writing one then zero to misc bit 5 clears timer interrupt request.
// - misc bit 4 enables isa channel check as a wake event.
// - misc bit 3 enables pci parity error as a wake event.
// - misc bit 2 enables non-maskable interrupt as a wake event.
// - misc bit 1 enables processor interrupt output as a wake event.
// - misc bit 0 is the global wake enable gating all detection.
// - dma enable register bit n enables wake on dma request n.
// - all four enable registers reset to zero.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module bed_break_event_detect (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // wake sources
  input  wire logic [15:0] irqReq,
  input  wire logic [7:0]  dmaReq,
  input  wire logic        serrN,
  input  wire logic        perrN,
  input  wire logic        iochkN,
  input  wire logic        nmi,
  input  wire logic        intr,
  // to the sequencer and the system
  output var  logic        pmActivityN,
  output var  logic        timerIrqClear,
  output var  logic        intReq
);
  // ********************************
  // registers
  // ********************************
  logic [7:0] irqLowWakeEnable;
  logic [7:0] irqHighWakeEnable;
  logic [7:0] miscWakeEnable;
  logic [7:0] dmaWakeEnable;
  logic [1:0] status;
  logic [1:0] mask;

  // ********************************
  // bus decode
  // ********************************
  wire logic       setupPhase = psel & ~penable;
  wire logic       accessDone = psel & penable & pready;
  wire logic       wrDone     = accessDone & pwrite;
  wire logic       hitLow     = paddr == bed_pkg::OFF_IRQ_LOW_EN;
  wire logic       hitHigh    = paddr == bed_pkg::OFF_IRQ_HIGH_EN;
  wire logic       hitMisc    = paddr == bed_pkg::OFF_MISC_EN;
  wire logic       hitDma     = paddr == bed_pkg::OFF_DMA_EN;
  wire logic       hitStatus  = paddr == bed_pkg::OFF_STATUS;
  wire logic       hitMask    = paddr == bed_pkg::OFF_MASK;
  wire logic       mapped     = hitLow | hitHigh | hitMisc | hitDma | hitStatus | hitMask;
  wire logic [7:0] wrByte     = pwdata[7:0];
  wire logic [7:0] rdByte     = hitLow    ? irqLowWakeEnable  :
                                hitHigh   ? irqHighWakeEnable :
                                hitMisc   ? miscWakeEnable    :
                                hitDma    ? dmaWakeEnable     :
                                hitStatus ? {6'h00, status}   :
                                hitMask   ? {6'h00, mask}     : 8'h00;

  // ********************************
  // source detection
  // ********************************
  // per-line gating; one loop covers both interrupt enable registers
  wire logic [15:0] irqEnable = {irqHighWakeEnable, irqLowWakeEnable};
  wire logic [15:0] irqHit;
  wire logic [7:0]  dmaHit;
  genvar gi;
  generate
    for (gi = 0; gi < bed_pkg::IRQ_LINES; gi++) begin : g_irq
      assign irqHit[gi] = irqReq[gi] & irqEnable[gi];
    end
    for (gi = 0; gi < bed_pkg::DMA_CHANS; gi++) begin : g_dma
      assign dmaHit[gi] = dmaReq[gi] & dmaWakeEnable[gi];
    end
  endgenerate

  wire logic serrHit  = ~serrN  & miscWakeEnable[bed_pkg::MISC_SERR];
  wire logic iochkHit = ~iochkN & miscWakeEnable[bed_pkg::MISC_IOCHK];
  wire logic perrHit  = ~perrN  & miscWakeEnable[bed_pkg::MISC_PERR];
  wire logic nmiHit   = nmi     & miscWakeEnable[bed_pkg::MISC_NMI];
  wire logic intrHit  = intr    & miscWakeEnable[bed_pkg::MISC_INTR];
  wire logic anyHit   = (|irqHit) | (|dmaHit) | serrHit | iochkHit | perrHit | nmiHit | intrHit;
  // no wake at all unless the global enable is set
  wire logic breakDetect = anyHit & miscWakeEnable[bed_pkg::MISC_GLOBAL];

  // timer request clear fires on the falling write of the clear bit
  wire logic clrFall = wrDone & hitMisc & miscWakeEnable[bed_pkg::MISC_TMR_CLR]
                       & ~wrByte[bed_pkg::MISC_TMR_CLR];

  // ********************************
  // interrupt status
  // ********************************
  wire logic [1:0] statSet  = {clrFall, breakDetect};
  wire logic [1:0] statClr  = (wrDone & hitStatus) ? wrByte[1:0] : 2'h0;
  // set wins over a write-one-to-clear in the same cycle
  wire logic [1:0] next_status = (status & ~statClr) | statSet;

  // ********************************
  // apb answer
  // ********************************
  // no wait state; pready rises in the first access cycle, and every bus output still comes from a flop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= bed_pkg::RD_ZERO;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      prdata  <= setupPhase ? {24'h00_0000, rdByte} : bed_pkg::RD_ZERO;
      pslverr <= setupPhase & ~mapped;
    end
  end

  // ********************************
  // enable and mask registers
  // ********************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqLowWakeEnable  <= bed_pkg::EN_RST;
      irqHighWakeEnable <= bed_pkg::EN_RST;
      miscWakeEnable    <= bed_pkg::EN_RST;
      dmaWakeEnable     <= bed_pkg::EN_RST;
      mask              <= bed_pkg::STAT_RST;
    end else begin
      if (wrDone && hitLow) begin
        irqLowWakeEnable <= wrByte;
      end
      if (wrDone && hitHigh) begin
        irqHighWakeEnable <= wrByte;
      end
      if (wrDone && hitMisc) begin
        miscWakeEnable <= wrByte & bed_pkg::MISC_WMASK;
      end
      if (wrDone && hitDma) begin
        dmaWakeEnable <= wrByte;
      end
      if (wrDone && hitMask) begin
        mask <= wrByte[1:0];
      end
    end
  end

  // ********************************
  // outputs
  // ********************************
  // activity goes high one cycle after each cycle a wake source is seen, low otherwise
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pmActivityN   <= bed_pkg::PM_ACT_RST;
      timerIrqClear <= 1'b0;
      status        <= bed_pkg::STAT_RST;
      intReq        <= 1'b0;
    end else begin
      pmActivityN   <= breakDetect;
      timerIrqClear <= clrFall;
      status        <= next_status;
      intReq        <= |(next_status & mask);
    end
  end

  // ********************************
  // checks
  // ********************************
  property p_wake;
    @(posedge ref_clk) disable iff (!rst_b)
    breakDetect |=> pmActivityN;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not signalled");

  property p_irq_low;
    @(posedge ref_clk) disable iff (!rst_b)
    (miscWakeEnable[0] && |(irqReq[7:0] & irqLowWakeEnable)) |=> pmActivityN;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("low irq wake lost");

  property p_irq_high;
    @(posedge ref_clk) disable iff (!rst_b)
    (miscWakeEnable[0] && |(irqReq[15:8] & irqHighWakeEnable)) |=> pmActivityN;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("high irq wake lost");

  property p_serr;
    @(posedge ref_clk) disable iff (!rst_b)
    (miscWakeEnable[0] && miscWakeEnable[6] && !serrN) |=> pmActivityN;
  endproperty
  a_serr: assert property (p_serr) else $error("serr wake lost");

  property p_tmr_clr;
    @(posedge ref_clk) disable iff (!rst_b)
    (wrDone && hitMisc && miscWakeEnable[5] && !pwdata[5]) |=> timerIrqClear ##1 !timerIrqClear;
  endproperty
  a_tmr_clr: assert property (p_tmr_clr) else $error("timer clear not pulsed");

  property p_tmr_cause;
    @(posedge ref_clk) disable iff (!rst_b)
    timerIrqClear |-> $past(miscWakeEnable[5]) && !miscWakeEnable[5];
  endproperty
  a_tmr_cause: assert property (p_tmr_cause) else $error("spurious timer clear");

  property p_iochk;
    @(posedge ref_clk) disable iff (!rst_b)
    (miscWakeEnable[0] && miscWakeEnable[4] && !iochkN) |=> pmActivityN;
  endproperty
  a_iochk: assert property (p_iochk) else $error("iochk wake lost");

  property p_perr;
    @(posedge ref_clk) disable iff (!rst_b)
    (miscWakeEnable[0] && miscWakeEnable[3] && !perrN) |=> pmActivityN;
  endproperty
  a_perr: assert property (p_perr) else $error("perr wake lost");

  property p_nmi;
    @(posedge ref_clk) disable iff (!rst_b)
    (miscWakeEnable[0] && miscWakeEnable[2] && nmi) |=> pmActivityN;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi wake lost");

  property p_intr;
    @(posedge ref_clk) disable iff (!rst_b)
    (miscWakeEnable[0] && miscWakeEnable[1] && intr) |=> pmActivityN;
  endproperty
  a_intr: assert property (p_intr) else $error("intr wake lost");

  property p_global_off;
    @(posedge ref_clk) disable iff (!rst_b)
    !miscWakeEnable[0] |=> !pmActivityN;
  endproperty
  a_global_off: assert property (p_global_off) else $error("wake while globally off");

  property p_dma;
    @(posedge ref_clk) disable iff (!rst_b)
    (miscWakeEnable[0] && |(dmaReq & dmaWakeEnable)) |=> pmActivityN;
  endproperty
  a_dma: assert property (p_dma) else $error("dma wake lost");

  property p_reset_zero;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(rst_b) |-> (irqLowWakeEnable == 8'h00) && (irqHighWakeEnable == 8'h00)
                     && (miscWakeEnable == 8'h00) && (dmaWakeEnable == 8'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("enable not zero after reset");

  property p_no_cause;
    @(posedge ref_clk) disable iff (!rst_b)
    pmActivityN |-> $past(breakDetect);
  endproperty
  a_no_cause: assert property (p_no_cause) else $error("activity high without source");

  property p_reserved;
    @(posedge ref_clk) disable iff (!rst_b)
    (wrDone && hitMisc) |=> !miscWakeEnable[7] && miscWakeEnable[6:0] == $past(pwdata[6:0]);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit stored");

  // a completing write may clear status or change the mask, so it is left out here
  property p_irq_line;
    @(posedge ref_clk) disable iff (!rst_b)
    (status[0] && mask[0] && !wrDone) |=> intReq;
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("interrupt not raised");

  property p_status_set;
    @(posedge ref_clk) disable iff (!rst_b)
    breakDetect |=> status[0];
  endproperty
  a_status_set: assert property (p_status_set) else $error("wake status not set");

  property p_tmr_once;
    @(posedge ref_clk) disable iff (!rst_b)
    timerIrqClear |=> !timerIrqClear;
  endproperty
  a_tmr_once: assert property (p_tmr_once) else $error("timer clear longer than one cycle");

  property p_ready_pulse;
    @(posedge ref_clk) disable iff (!rst_b)
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  property p_err_with_ready;
    @(posedge ref_clk) disable iff (!rst_b)
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
endmodule : bed_break_event_detect
`default_nettype wire

// [bed_src_model.sv]
// source model: drives the interrupt, dma and error lines seen by the detector
// assumes bench commands change right after rising edges of ref_clk
`timescale 1ns/1ps
`default_nettype none
module bed_src_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // bench commands
  input  wire logic [15:0] irqSet,
  input  wire logic [7:0]  dmaSet,
  input  wire logic [4:0]  errSet,
  input  wire logic        timerRaise,
  input  wire logic        timerIrqClear,
  // lines to the detector
  output var  logic [15:0] irqReq,
  output var  logic [7:0]  dmaReq,
  output var  logic        serrN,
  output var  logic        perrN,
  output var  logic        iochkN,
  output var  logic        nmi,
  output var  logic        intr
);
  logic timerPend;
  // timer request stays pending until the detector clears it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) timerPend <= 1'b0;
    else if (timerRaise) timerPend <= 1'b1;
    else if (timerIrqClear) timerPend <= 1'b0;
  end
  assign irqReq = irqSet | {15'h0000, timerPend};
  assign dmaReq = dmaSet;
  // serr, iochk and perr lines idle high, active low; nmi and intr are active high
  assign serrN  = ~errSet[4];
  assign iochkN = ~errSet[3];
  assign perrN  = ~errSet[2];
  assign nmi    = errSet[1];
  assign intr   = errSet[0];
endmodule : bed_src_model
`default_nettype wire

// [bed_break_event_detect_tb.sv]
// testbench for the break event detector, with the source model beside it
// assumes the apb slave answers with pready and sources are synchronous
`timescale 1ns/1ps
`default_nettype none
module bed_break_event_detect_tb;
  logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, se, pmActivityN, timerIrqClear, intReq, serrN, perrN, iochkN, nmi, intr;
  logic [15:0] irqSet = 16'h0000, irqReq;
  logic [7:0] dmaSet = 8'h00, dmaReq;
  logic [4:0] errSet = 5'h00;
  logic timerRaise = 1'b0;
  int errCount, checkCount, cycles;
  always #50 ref_clk = ~ref_clk;
  bed_break_event_detect i_bed_break_event_detect (.ref_clk(ref_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irqReq(irqReq), .dmaReq(dmaReq),
    .serrN(serrN), .perrN(perrN), .iochkN(iochkN), .nmi(nmi), .intr(intr),
    .pmActivityN(pmActivityN), .timerIrqClear(timerIrqClear), .intReq(intReq));
  bed_src_model i_bed_src_model (.ref_clk(ref_clk), .rst_b(rst_b), .irqSet(irqSet),
    .dmaSet(dmaSet), .errSet(errSet), .timerRaise(timerRaise),
    .timerIrqClear(timerIrqClear), .irqReq(irqReq), .dmaReq(dmaReq), .serrN(serrN),
    .perrN(perrN), .iochkN(iochkN), .nmi(nmi), .intr(intr));
  // ********************************
  // checks and bus
  // ********************************
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task conclude;
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // no wait count assumed; a dead slave is caught by the cycle ceiling
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task settle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : settle
  // ********************************
  // scenarios
  // ********************************
  task t_regs;
    logic [7:0] offs [3];
    offs = '{bed_pkg::OFF_IRQ_LOW_EN, bed_pkg::OFF_IRQ_HIGH_EN, bed_pkg::OFF_DMA_EN};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000); chk("reset value", rd, 32'h0000_0000);
      chk("mapped err", {31'h0000_0000, se}, 32'h0000_0000);
    end
    apb(1'b1, 8'h18, 32'h0000_00FF);
    apb(1'b0, 8'h18, 32'h0000_0000); chk("unmapped err", {31'h0000_0000, se}, 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    foreach (offs[i]) begin
      apb(1'b1, offs[i], 32'h0000_00A5);
      apb(1'b0, offs[i], 32'h0000_0000); chk("rw enable", rd, 32'h0000_00A5);
      apb(1'b1, offs[i], 32'h0000_0000);
    end
  endtask : t_regs
  task t_lines(input logic dma);
    apb(1'b1, bed_pkg::OFF_MISC_EN, 32'h0000_0001);
    for (int n = 0; n < (dma ? 8 : 16); n++) begin
      apb(1'b1, dma ? bed_pkg::OFF_DMA_EN : (n < 8 ? bed_pkg::OFF_IRQ_LOW_EN
          : bed_pkg::OFF_IRQ_HIGH_EN), 32'(1 << (n % 8)));
      if (dma) dmaSet <= 8'(1 << (n ^ 1)); else irqSet <= 16'(1 << (n ^ 1));
      settle(2); chk("other line", pmActivityN, 0);
      if (dma) dmaSet <= 8'(1 << n); else irqSet <= 16'(1 << n);
      settle(2); chk("own line", pmActivityN, 1);
      irqSet <= 16'h0000; dmaSet <= 8'h00;
    end
  endtask : t_lines
  task t_misc;
    int b [5];
    b = '{1, 2, 3, 4, 6};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, bed_pkg::OFF_MISC_EN, 32'h0000_0001);
      errSet <= 5'(1 << i); settle(2); chk("misc off", pmActivityN, 0);
      apb(1'b1, bed_pkg::OFF_MISC_EN, 32'(1 | (1 << b[i])));
      settle(2); chk("misc on", pmActivityN, 1);
      errSet <= 5'h00;
    end
    apb(1'b1, bed_pkg::OFF_MISC_EN, 32'h0000_005E); errSet <= 5'h1F;
    settle(2); chk("global off", pmActivityN, 0);
    apb(1'b1, bed_pkg::OFF_MISC_EN, 32'h0000_005F);
    settle(2); chk("global on", pmActivityN, 1);
    errSet <= 5'h00; settle(1); chk("drop lag", pmActivityN, 1);
    settle(1); chk("drop", pmActivityN, 0);
    errSet <= 5'h01; settle(1); chk("rise lag", pmActivityN, 0);
    settle(1); chk("rise", pmActivityN, 1);
    errSet <= 5'h00;
  endtask : t_misc
  task t_timer;
    logic hit;
    hit = 1'b0;
    timerRaise <= 1'b1; settle(1); timerRaise <= 1'b0;
    settle(1); chk("timer pending", irqReq[0], 1);
    apb(1'b1, bed_pkg::OFF_MISC_EN, 32'h0000_00FF);
    apb(1'b0, bed_pkg::OFF_MISC_EN, 32'h0000_0000); chk("misc read", rd, 32'h0000_007F);
    apb(1'b1, bed_pkg::OFF_MISC_EN, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      if (timerIrqClear === 1'b1) hit = 1'b1;
    end
    chk("clear pulse", hit, 1);
    chk("timer cleared", irqReq[0], 0);
  endtask : t_timer
  task t_intr;
    apb(1'b0, bed_pkg::OFF_STATUS, 32'h0000_0000); chk("status", rd, 32'h0000_0003);
    apb(1'b1, bed_pkg::OFF_MASK, 32'h0000_0001); settle(2); chk("irq on", intReq, 1);
    apb(1'b1, bed_pkg::OFF_MASK, 32'h0000_0000); settle(2); chk("irq masked", intReq, 0);
    apb(1'b1, bed_pkg::OFF_MASK, 32'h0000_0003);
    apb(1'b1, bed_pkg::OFF_STATUS, 32'h0000_0003); settle(2); chk("irq cleared", intReq, 0);
    apb(1'b0, bed_pkg::OFF_STATUS, 32'h0000_0000); chk("status clr", rd, 32'h0000_0000);
  endtask : t_intr
  // mid-run reset must drop every enable and the activity output
  task t_reset;
    apb(1'b1, bed_pkg::OFF_IRQ_LOW_EN, 32'h0000_00FF);
    apb(1'b1, bed_pkg::OFF_MISC_EN, 32'h0000_00FF);
    apb(1'b1, bed_pkg::OFF_DMA_EN, 32'h0000_00FF);
    irqSet <= 16'h0001;
    settle(2); chk("wake before reset", pmActivityN, 1);
    rst_b <= 1'b0;
    settle(2); chk("wake in reset", pmActivityN, 0);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000); chk("enable after reset", rd, 32'h0000_0000);
    end
    settle(1); chk("no wake after reset", pmActivityN, 0);
    irqSet <= 16'h0000;
  endtask : t_reset
  // ********************************
  // run
  // ********************************
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errCount++;
      conclude;
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs;
    t_lines(1'b0);
    t_lines(1'b1);
    t_misc;
    t_timer;
    t_intr;
    t_reset;
    conclude;
  end
endmodule : bed_break_event_detect_tb
`default_nettype wire
